/* rtl/psm_low_timer.sv */
/*
 * Measures how long an active-low line stays low, in clock cycles.
 * Assumes the line may be asynchronous; it is synchronised first.
 */
`timescale 1ns/1ns
module psm_low_timer
    import psm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_n,
    output logic [CNT_W-1:0] low_cycles,
    output logic released,
    output logic [CNT_W-1:0] rel_cycles
);
    logic sync1;
    logic sync2;
    logic low_q;
    wire low = !sync2;
    wire sat = &low_cycles;

    // Sampled, synchronised counter keeps every threshold test exact
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            low_q <= 1'b0;
            low_cycles <= '0;
            released <= 1'b0;
            rel_cycles <= '0;
        end else begin
            sync1 <= line_n;
            sync2 <= sync1;
            low_q <= low;
            released <= low_q && !low;
            if (low_q && !low)
                rel_cycles <= low_cycles;
            if (!low)
                low_cycles <= '0;
            else if (!sat)
                low_cycles <= low_cycles + 1'b1;
        end
    end
endmodule // psm_low_timer

/* rtl/psm_pkg.sv */
/*
 * Shared constants and types of the module power-state manager.
 * Assumes a 10 MHz controller clock; supply comparisons arrive as
 * ready-made comparator levels synchronous to that clock.
 */
package psm_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int CNT_W = 26;

    // Line low times and the alert gap, in milliseconds
    localparam int unsigned IGN_NORMAL_MS = 100;
    localparam int unsigned IGN_CHG_MIN_MS = 100;
    localparam int unsigned IGN_CHG_MAX_MS = 500;
    localparam int unsigned IGN_CHGNORM_MS = 1000;
    localparam int unsigned PD_OFF_MS = 3500;
    localparam int unsigned ALERT_GAP_MS = 1000;
    localparam int unsigned IGN_NORMAL_CYC = IGN_NORMAL_MS * CYC_PER_MS;
    localparam int unsigned IGN_CHG_MIN_CYC = IGN_CHG_MIN_MS * CYC_PER_MS;
    localparam int unsigned IGN_CHG_MAX_CYC = IGN_CHG_MAX_MS * CYC_PER_MS;
    localparam int unsigned IGN_CHGNORM_CYC = IGN_CHGNORM_MS * CYC_PER_MS;
    localparam int unsigned PD_OFF_CYC = PD_OFF_MS * CYC_PER_MS;
    localparam int unsigned ALERT_GAP_CYC = ALERT_GAP_MS * CYC_PER_MS;

    localparam logic [2:0] ALERT_REPEATS = 3'h3;
    localparam logic [2:0] ALERT_ONCE = 3'h1;

    // Register map
    localparam logic [3:0] CMD_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int CMD_ALERT_BIT = 0;
    localparam int CMD_OFF_BIT = 1;
    localparam int CMD_ALARM_BIT = 2;
    localparam int CMD_CONS_LSB = 8;
    localparam int CMD_CONS_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        PSM_OFF = 5'h01,
        PSM_NORMAL = 5'h02,
        PSM_CHG_ONLY = 5'h04,
        PSM_CHG_NORM = 5'h08,
        PSM_ALARM = 5'h10
    } psm_mode_t;

    typedef struct packed {
        logic charger;
        logic temp_sensor;
        logic below_3v3;
        logic above_3v0;
        logic above_5v8;
        logic alarm_due;
    } psm_sense_t;
endpackage

/* rtl/psm_top.sv */
/*
 * Power-state manager: mode sequencing, supply supervision and an
 * AXI4-Lite command/status port. Assumes sense levels are synchronous
 * comparator outputs and the host drives both lines open-drain.
 */
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// How it works
// - With sensor, supply below 3.3V raises the low-supply message if enabled.
// - With sensor, alert enable needs the alert command with a consumption value.
// - With sensor, the low-supply message repeats before automatic shutdown.
// - Undervoltage shutdown works without sensor, fixed supply or external charger.
// - Without sensor, any alert command enables alerts, value optional.
// - Without sensor, one low-supply message, then silent shutdown.
// - Supply above 5.8V switches off at once.
// - Overvoltage shutdown sends no message.
// - From off without charger or alarm, ignition low over 100 ms: normal.
// - From off without charger, charger appearing gives charge-only.
// - Off with charger, ignition low 100 to 500 ms: charge-only.
// - Off with charger or charge-only, ignition low over 1 s: charging-normal.
// - Off with charger, ignition start needs supply above 3.0V.
// - Power-down line low over 3.5 s or switch-off command: off; the command gives charge-only from charging-normal.
// - Armed alarm wakes into alarm; from charge-only also needs supply <=3.3V.
// - Charge-only with charger gone: off.
// - Charging-normal with charger gone: normal.
// - No direct step from off without charger into charging-normal.
// - Command switch-off into off sends an off message, then commands are ignored.
module psm_top
    import psm_pkg::*;
#(
    parameter int unsigned IGN_NORM_P = IGN_NORMAL_CYC,
    parameter int unsigned IGN_CMIN_P = IGN_CHG_MIN_CYC,
    parameter int unsigned IGN_CMAX_P = IGN_CHG_MAX_CYC,
    parameter int unsigned IGN_CNRM_P = IGN_CHGNORM_CYC,
    parameter int unsigned PD_OFF_P = PD_OFF_CYC,
    parameter int unsigned ALERT_GAP_P = ALERT_GAP_CYC
)(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic IGNITION_LINE_N,
    input wire logic HARD_POWER_DOWN_LINE_N,
    input wire psm_sense_t SENSE,
    output psm_mode_t MODE,
    output logic LOW_SUPPLY_MESSAGE,
    output logic OFF_MESSAGE,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    localparam logic [CNT_W-1:0] IGN_NORM = CNT_W'(IGN_NORM_P);
    localparam logic [CNT_W-1:0] IGN_CMIN = CNT_W'(IGN_CMIN_P);
    localparam logic [CNT_W-1:0] IGN_CMAX = CNT_W'(IGN_CMAX_P);
    localparam logic [CNT_W-1:0] IGN_CNRM = CNT_W'(IGN_CNRM_P);
    localparam logic [CNT_W-1:0] PD_OFF = CNT_W'(PD_OFF_P);
    localparam logic [CNT_W-1:0] GAP = CNT_W'(ALERT_GAP_P);

    function automatic logic crossed(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] lim);
        // True once, on the first cycle the low time exceeds lim
        crossed = (cnt == lim + 1'b1);
    endfunction

    psm_mode_t state;
    psm_mode_t next_state;
    logic alert_en;
    logic alarm_armed;
    logic charger_q;
    logic [2:0] uv_sent;
    logic [CNT_W-1:0] uv_gap;
    logic [CNT_W-1:0] ign_low;
    logic [CNT_W-1:0] ign_rel_cyc;
    logic ign_rel;
    logic [CNT_W-1:0] pd_low;

    psm_low_timer u_ign (
        .clk(CLK),
        .rst_n(RST_N),
        .line_n(IGNITION_LINE_N),
        .low_cycles(ign_low),
        .released(ign_rel),
        .rel_cycles(ign_rel_cyc)
    );

    psm_low_timer u_pd (
        .clk(CLK),
        .rst_n(RST_N),
        .line_n(HARD_POWER_DOWN_LINE_N),
        .low_cycles(pd_low),
        .released(),
        .rel_cycles()
    );

    // Bus slave: address and data are taken together in one cycle
    wire wr_take = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
                   && !S_AXI_AWREADY;
    wire rd_take = S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
    wire wr_cmd = wr_take && S_AXI_AWADDR == CMD_ADDR && S_AXI_WSTRB[0];
    wire wr_hit = S_AXI_AWADDR == CMD_ADDR;
    wire rd_hit = S_AXI_ARADDR == CMD_ADDR || S_AXI_ARADDR == STATUS_ADDR;
    wire [CMD_CONS_W-1:0] cons = S_AXI_WDATA[CMD_CONS_LSB +: CMD_CONS_W];
    wire [31:0] rd_word = (S_AXI_ARADDR == CMD_ADDR)
                          ? {31'h0, alert_en}
                          : {24'h0, alarm_armed, SENSE.temp_sensor,
                             state == PSM_OFF, state};

    // A switched-off engine executes no command
    wire cmd_ok = wr_cmd && state != PSM_OFF;
    wire cmd_alert = cmd_ok && S_AXI_WDATA[CMD_ALERT_BIT];
    wire cmd_off = cmd_ok && S_AXI_WDATA[CMD_OFF_BIT];
    wire cmd_alarm = cmd_ok && S_AXI_WDATA[CMD_ALARM_BIT];
    // With sensor the consumption value must be given without, not
    wire alert_on = cmd_alert && (!SENSE.temp_sensor || cons != '0);

    // Supply supervision
    wire uv_mode = state == PSM_NORMAL || state == PSM_CHG_NORM
                   || state == PSM_ALARM;
    // Sensor fitted: repeated warnings none fitted: a single one
    wire [2:0] uv_limit = SENSE.temp_sensor ? ALERT_REPEATS : ALERT_ONCE;
    wire uv_due = uv_mode && SENSE.below_3v3 && uv_gap == '0;
    wire uv_emit = uv_due && uv_sent < uv_limit;
    // Shutdown does not depend on alerts being enabled
    wire uv_shut = uv_due && uv_sent >= uv_limit;
    // Overvoltage cuts the supply at once, skipping any message
    wire ovp = state != PSM_OFF && SENSE.above_5v8;
    wire pd_hit = state != PSM_OFF && crossed(pd_low, PD_OFF);

    wire ign_norm = crossed(ign_low, IGN_NORM);
    wire ign_cnrm = crossed(ign_low, IGN_CNRM);
    wire ign_short = ign_rel && ign_rel_cyc > IGN_CMIN
                     && ign_rel_cyc < IGN_CMAX;
    wire chg_rise = SENSE.charger && !charger_q;
    wire wake_due = alarm_armed && SENSE.alarm_due;

    always_comb begin
        next_state = state;
        case (state)
            PSM_OFF: begin
                if (!SENSE.charger && ign_norm)
                    next_state = PSM_NORMAL;
                else if (chg_rise)
                    next_state = PSM_CHG_ONLY;
                else if (SENSE.charger && ign_short)
                    next_state = PSM_CHG_ONLY;
                else if (SENSE.charger && SENSE.above_3v0 && ign_cnrm)
                    next_state = PSM_CHG_NORM;
                else if (wake_due)
                    next_state = PSM_ALARM;
            end
            PSM_NORMAL: begin
                if (SENSE.charger)
                    next_state = PSM_CHG_NORM;
            end
            PSM_CHG_ONLY: begin
                if (!SENSE.charger)
                    next_state = PSM_OFF;
                else if (ign_cnrm)
                    next_state = PSM_CHG_NORM;
                else if (wake_due && SENSE.below_3v3)
                    next_state = PSM_ALARM;
            end
            PSM_CHG_NORM: begin
                if (!SENSE.charger)
                    next_state = PSM_NORMAL;
            end
            PSM_ALARM: begin
                if (ign_norm)
                    next_state = SENSE.charger ? PSM_CHG_NORM : PSM_NORMAL;
            end
            default: next_state = PSM_OFF;
        endcase
        // Shutdown causes override the mode steps above
        if (ovp || pd_hit || uv_shut)
            next_state = PSM_OFF;
        else if (cmd_off)
            next_state = (state == PSM_CHG_NORM) ? PSM_CHG_ONLY
                                                 : PSM_OFF;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= PSM_OFF;
            // A charger already present at reset is no arrival
            charger_q <= SENSE.charger;
            OFF_MESSAGE <= 1'b0;
        end else begin
            state <= next_state;
            charger_q <= SENSE.charger;
            // Announce the off state before going quiet
            OFF_MESSAGE <= cmd_off && !ovp && !pd_hit && !uv_shut
                           && state != PSM_CHG_NORM;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            alert_en <= 1'b0;
            alarm_armed <= 1'b0;
        end else begin
            if (alert_on)
                alert_en <= 1'b1;
            // The arming command wins over a simultaneous wake
            if (cmd_alarm)
                alarm_armed <= 1'b1;
            else if (next_state == PSM_ALARM && state != PSM_ALARM)
                alarm_armed <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            uv_sent <= '0;
            uv_gap <= '0;
            LOW_SUPPLY_MESSAGE <= 1'b0;
        end else begin
            LOW_SUPPLY_MESSAGE <= uv_emit && alert_en && !ovp;
            if (!uv_mode) begin
                uv_sent <= '0;
                uv_gap <= '0;
            end else if (uv_emit) begin
                uv_sent <= uv_sent + 1'b1;
                uv_gap <= SENSE.temp_sensor ? GAP : '0;
            end else if (uv_gap != '0) begin
                uv_gap <= uv_gap - 1'b1;
            end
        end
    end

    assign MODE = state;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= wr_take;
            S_AXI_WREADY <= wr_take;
            if (wr_take) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            S_AXI_ARREADY <= rd_take;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_hit ? rd_word : 32'h0;
                S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_off_cmd;
        cmd_off && state == PSM_NORMAL && !ovp && !pd_hit && !uv_shut;
    endsequence

    sequence s_off_announced;
        OFF_MESSAGE && state == PSM_OFF;
    endsequence

    a_ovp_cutoff: assert property (
        ovp |=> state == PSM_OFF)
        else $error("overvoltage did not switch off");
    a_ovp_silent: assert property (
        ovp |=> !OFF_MESSAGE && !LOW_SUPPLY_MESSAGE)
        else $error("message sent on overvoltage");
    a_cmd_off_msg: assert property (
        s_off_cmd |=> s_off_announced ##1 !OFF_MESSAGE)
        else $error("switch-off not announced");
    a_off_no_cmd: assert property (
        state == PSM_OFF && wr_cmd |=> $stable(alert_en)
            && !$rose(alarm_armed))
        else $error("command taken while off");
    a_pd_held_off: assert property (
        state != PSM_OFF && pd_low == PD_OFF + 1'b1 |=> state == PSM_OFF)
        else $error("power-down line ignored");
    a_ign_to_normal: assert property (
        state == PSM_OFF && !SENSE.charger && !ovp
            && ign_low == IGN_NORM + 1'b1 |=> state == PSM_NORMAL)
        else $error("ignition did not start");
    a_no_direct_cnrm: assert property (
        state == PSM_OFF && !SENSE.charger |=> state != PSM_CHG_NORM)
        else $error("direct step into charging-normal");
    a_charger_gone: assert property (
        state == PSM_CHG_NORM && !SENSE.charger && !ovp && !pd_hit
            && !uv_shut && !cmd_off |=> state == PSM_NORMAL)
        else $error("charger removal not handled");
    a_uv_single: assert property (
        LOW_SUPPLY_MESSAGE && !SENSE.temp_sensor
            |-> ##1 !LOW_SUPPLY_MESSAGE [*2])
        else $error("second low-supply message without sensor");
    a_chg_only_drop: assert property (
        state == PSM_CHG_ONLY && !SENSE.charger |=> state == PSM_OFF)
        else $error("charge-only kept without charger");
    a_charger_wakes: assert property (
        state == PSM_OFF && chg_rise |=> state == PSM_CHG_ONLY)
        else $error("charger arrival did not give charge-only");
    a_short_ign_chg: assert property (
        state == PSM_OFF && SENSE.charger && ign_short
            |=> state == PSM_CHG_ONLY)
        else $error("short ignition with charger ignored");
    a_cnrm_from_chg: assert property (
        state == PSM_CHG_ONLY && SENSE.charger && ign_cnrm && !ovp
            && !pd_hit && !cmd_off |=> state == PSM_CHG_NORM)
        else $error("long ignition in charge-only ignored");
    a_cnrm_low_supply: assert property (
        state == PSM_OFF && !SENSE.above_3v0 |=> state != PSM_CHG_NORM)
        else $error("start with supply too low");
    a_alarm_wake: assert property (
        state == PSM_OFF && wake_due && !chg_rise && !ign_rel
            && ign_low == '0 |=> state == PSM_ALARM)
        else $error("armed alarm did not wake");
    a_alarm_chg_high: assert property (
        state == PSM_CHG_ONLY && !SENSE.below_3v3 |=> state != PSM_ALARM)
        else $error("alarm wake from charge-only with good supply");
    a_alert_needs_cons: assert property (
        SENSE.temp_sensor && !alert_en && (!cmd_alert || cons == '0)
            |=> !alert_en)
        else $error("alerts enabled without consumption value");
    a_alert_auto: assert property (
        !SENSE.temp_sensor && cmd_alert |=> alert_en)
        else $error("alert command did not enable alerts");
    a_low_msg_gate: assert property (
        LOW_SUPPLY_MESSAGE |-> $past(alert_en) && $past(SENSE.below_3v3))
        else $error("low-supply message while not due");
    a_uv_silent_off: assert property (
        uv_shut |=> !OFF_MESSAGE && !LOW_SUPPLY_MESSAGE)
        else $error("message sent on undervoltage shutdown");
endmodule // psm_top

/* testbench/module_power_state_manager_bench.sv */
/*
 * Self-checking bench of the power-state manager with a mode model.
 * Assumes the host model on the lines and an AXI4-Lite master here.
 */
`timescale 1ns/1ns
module module_power_state_manager_bench;
    import psm_pkg::*;
    localparam int NP = 20, CMN = 20, CMX = 60, CNR = 120, PDP = 200;
    localparam int GAP = 10, LIMIT = 20000;
    localparam int EV_IGN = 0, EV_CHG = 1, EV_PD = 2, EV_OFF = 3;
    localparam int EV_WAKE = 4, EV_SHUT = 5;
    logic CLK, RST_N, ign_n, pd_n, lsm, offm;
    psm_sense_t sense;
    psm_mode_t MODE, em;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [7:0] cons;
    int fails, tests_run, cyc, n_low, n_off;

    psm_top #(.IGN_NORM_P(NP), .IGN_CMIN_P(CMN), .IGN_CMAX_P(CMX),
        .IGN_CNRM_P(CNR), .PD_OFF_P(PDP), .ALERT_GAP_P(GAP)) dut_u (
        .CLK(CLK), .RST_N(RST_N), .IGNITION_LINE_N(ign_n),
        .HARD_POWER_DOWN_LINE_N(pd_n), .SENSE(sense), .MODE(MODE),
        .LOW_SUPPLY_MESSAGE(lsm), .OFF_MESSAGE(offm),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    psm_host_model host_u (.clk(CLK), .ign_n(ign_n), .pd_n(pd_n));

    initial begin
        CLK = 1'h0;
        forever #50 CLK = ~CLK;
    end

    // Message pulses last one cycle, so they are tallied at every rising edge
    always @(posedge CLK) begin
        cyc++;
        if (lsm === 1'h1) n_low++;
        if (offm === 1'h1) n_off++;
        if (cyc == LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    task wrap_up();
        $display("Checks run: %0d, mismatches: %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk_mode(string what, psm_mode_t exp);
        tests_run++;
        if (MODE !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, MODE);
        end
    endtask

    task chk_val(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reference transition table; armed tracks a pending alarm wake
    bit armed;
    function automatic psm_mode_t model_next(psm_mode_t c, int ev, int ln);
        case (ev)
            EV_IGN: begin
                if (c == PSM_ALARM && ln > NP)
                    return sense.charger ? PSM_CHG_NORM : PSM_NORMAL;
                if (c == PSM_OFF && !sense.charger && ln > NP)
                    return PSM_NORMAL;
                if (c == PSM_OFF && sense.charger && ln > CNR && sense.above_3v0)
                    return PSM_CHG_NORM;
                if (c == PSM_OFF && sense.charger && ln > CMN && ln < CMX)
                    return PSM_CHG_ONLY;
                if (c == PSM_CHG_ONLY && ln > CNR)
                    return PSM_CHG_NORM;
            end
            EV_CHG: begin
                if (sense.charger && c == PSM_OFF) return PSM_CHG_ONLY;
                if (sense.charger && c == PSM_NORMAL) return PSM_CHG_NORM;
                if (!sense.charger && c == PSM_CHG_ONLY) return PSM_OFF;
                if (!sense.charger && c == PSM_CHG_NORM) return PSM_NORMAL;
            end
            EV_PD: if (ln > PDP) return PSM_OFF;
            EV_OFF: return (c == PSM_CHG_NORM) ? PSM_CHG_ONLY : PSM_OFF;
            EV_WAKE: if (armed && (c == PSM_OFF || c == PSM_CHG_ONLY
                         && sense.below_3v3)) return PSM_ALARM;
            EV_SHUT: return PSM_OFF;
            default: return c;
        endcase
        return c;
    endfunction

    task ev(int e, int ln, string what, int lim);
        int i;
        repeat (6) @(posedge CLK);
        em = model_next(em, e, ln);
        for (i = 0; i < lim && MODE !== em; i++) @(posedge CLK);
        chk_mode(what, em);
    endtask

    task ign(int ln, string what);
        host_u.hold_low(1'b0, ln);
        ev(EV_IGN, ln, what, 10);
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] dt);
        int n;
        @(posedge CLK);
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    task do_reset();
        RST_N <= 1'h0;
        repeat (8) @(posedge CLK);
        RST_N <= 1'h1;
        @(posedge CLK);
        em = PSM_OFF;
        armed = 0;
    endtask

    initial begin
        RST_N = 1'h0;
        sense = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hF;
        void'($urandom(78));
        do_reset();
        chk_mode("mode after reset", PSM_OFF);
        ign(CNR + 2 + $urandom % 8, "long ignition from off");
        n_off = 0;
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "switch-off command", 5);
        chk_val("off message count", 32'h1, n_off);
        axw(CMD_ADDR, 32'h1 << CMD_ALARM_BIT);
        rd(STATUS_ADDR);
        chk_val("arm ignored when off", 32'h0, {31'h0, d[7]});
        axw(4'h8, 32'h1);
        chk_val("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(4'hC);
        chk_val("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        @(posedge CLK) sense.charger <= 1'h1;
        ev(EV_CHG, 0, "charger on from off", 5);
        ign(CNR + 10, "long ignition in charge-only");
        @(posedge CLK) sense.charger <= 1'h0;
        ev(EV_CHG, 0, "charger off in charging", 5);
        @(posedge CLK) sense.charger <= 1'h1;
        ev(EV_CHG, 0, "charger on in normal", 5);
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "switch-off in charging", 5);
        @(posedge CLK) sense.charger <= 1'h0;
        ev(EV_CHG, 0, "charger off in charge-only", 5);
        @(posedge CLK) sense.charger <= 1'h1;
        ev(EV_CHG, 0, "charger on again", 5);
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "off with charger", 5);
        ign(CNR + 10, "start with low supply");
        ign(CMX + 20, "ignition in dead band");
        ign(CMN + 2 + $urandom % 30, "short ignition with charger");
        axw(CMD_ADDR, 32'h1 << CMD_ALARM_BIT);
        armed = 1;
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "off from charge-only", 5);
        @(posedge CLK) sense.alarm_due <= 1'h1;
        ev(EV_WAKE, 0, "alarm wake with charger", 5);
        armed = 0;
        @(posedge CLK) sense.alarm_due <= 1'h0;
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "off from alarm", 5);
        @(posedge CLK) sense.above_3v0 <= 1'h1;
        ign(CNR + 10, "start with good supply");
        @(posedge CLK) sense.charger <= 1'h0;
        ev(EV_CHG, 0, "charger removed", 5);
        host_u.hold_low(1'b1, PDP + 10);
        ev(EV_PD, PDP + 10, "power-down line", 10);
        ign(NP + 5, "restart");
        axw(CMD_ADDR, 32'h1 << CMD_ALARM_BIT);
        armed = 1;
        axw(CMD_ADDR, 32'h1 << CMD_OFF_BIT);
        ev(EV_OFF, 0, "off with alarm armed", 5);
        @(posedge CLK) sense.alarm_due <= 1'h1;
        ev(EV_WAKE, 0, "alarm wake", 5);
        @(posedge CLK) sense.alarm_due <= 1'h0;
        ign(NP + 2 + $urandom % 10, "ignition in alarm");
        n_low = 0;
        @(posedge CLK) sense.above_5v8 <= 1'h1;
        ev(EV_SHUT, 0, "overvoltage cut", 2);
        chk_val("overvoltage messages", 32'h0, n_low);
        @(posedge CLK) sense.above_5v8 <= 1'h0;
        for (int s = 1; s >= 0; s--) begin
            do_reset();
            @(posedge CLK) sense.temp_sensor <= s[0];
            ign(NP + 5, "start for undervoltage");
            axw(CMD_ADDR, 32'h1);
            rd(CMD_ADDR);
            chk_val("alert enable", {31'h0, !s[0]}, d);
            cons = 8'h1 + 8'($urandom % 255);
            axw(CMD_ADDR, 32'h1 | (32'(cons) << CMD_CONS_LSB));
            n_low = 0;
            n_off = 0;
            @(posedge CLK) sense.below_3v3 <= 1'h1;
            ev(EV_SHUT, 0, "undervoltage shutdown", 100);
            chk_val("low supply messages", s[0] ? 32'(ALERT_REPEATS) :
                32'(ALERT_ONCE), n_low);
            chk_val("undervoltage off msg", 32'h0, n_off);
            @(posedge CLK) sense.below_3v3 <= 1'h0;
        end
        wrap_up();
    end
endmodule // module_power_state_manager_bench

/* testbench/psm_host_model.sv */
/*
 * Host controller model: drives the ignition and power-down lines.
 * Assumes open-drain lines with pull-ups, so a released line reads high.
 */
`timescale 1ns/1ns
module psm_host_model (
    input wire logic clk,
    output logic ign_n,
    output logic pd_n
);
    initial begin
        ign_n = 1'h1;
        pd_n = 1'h1;
    end

    // Pulls one line low for len cycles, then drives both lines high again
    task automatic hold_low(input bit on_pd, input int len);
        @(posedge clk);
        if (on_pd) begin
            pd_n <= 1'h0;
        end else begin
            ign_n <= 1'h0;
        end
        repeat (len) @(posedge clk);
        pd_n <= 1'h1;
        ign_n <= 1'h1;
    endtask
endmodule // psm_host_model
